// [hw/srx_pkg.sv]
// Purpose: shared constants for the serial receive front end
// Assumes: 100 MHz clock, 8 data bits, no parity
// Notes: timing counts derived from printed figures
// Behaviour
// - line idles high, falling edge starts character
// - one start bit, one or two stops
// - ready low when free, high when busy
// - host sends only while ready is low
// - without ready, host pauses after characters
// - disable input defaults to enabled
// - disabled device ignores line, releases ready
// - host waits about 10 us after select
// - disabled at power-up restores factory defaults
// - device never drives transmit line
// - first byte carriage return sets baud
// - baud chosen from fixed candidate rates
package srx_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int SEL_WAIT_US = 10;
  localparam int SEL_WAIT_CYC = SEL_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int NUM_RATES = 6;
  // candidate rates, slowest first
  localparam int RATE_0 = 9600;
  localparam int RATE_1 = 14400;
  localparam int RATE_2 = 19200;
  localparam int RATE_3 = 38400;
  localparam int RATE_4 = 57600;
  localparam int RATE_5 = 115200;
  localparam int BIT_W = 16;
  // ----------------------------------------
  // framing
  // ----------------------------------------
  localparam logic [7:0] SYNC_CHAR = 8'h0d;
  localparam int DATA_BITS = 8;
  // cycles per bit for each candidate rate
  function automatic logic [BIT_W-1:0] srx_rate_cyc(input int idx);
    int r;
    case (idx)
      0: r = RATE_0;
      1: r = RATE_1;
      2: r = RATE_2;
      3: r = RATE_3;
      4: r = RATE_4;
      default: r = RATE_5;
    endcase
    return BIT_W'(CLK_HZ / r);
  endfunction : srx_rate_cyc
endpackage : srx_pkg

// [hw/srx_if.sv]
// Purpose: serial link between host and display receiver
// Assumes: single clock domain
// Notes: ready carried as a level and an enable, disable as one signal
`timescale 1ns/1ps
interface srx_if;
  logic rxLine; // serial data, idles high
  logic hostReadyNOut; // device ready level, low means ready
  logic hostReadyNOe; // low while device drives ready
  logic displayDisableN; // host select, low detaches device
  logic txLineOe; // device transmit enable, never low
  modport dev (
    input rxLine,
    input displayDisableN,
    output hostReadyNOut,
    output hostReadyNOe,
    output txLineOe
  );
  modport host (
    output rxLine,
    output displayDisableN,
    input hostReadyNOut,
    input hostReadyNOe,
    input txLineOe
  );
endinterface : srx_if

// [hw/srx_host.sv]
// Purpose: host-side transmitter for the display receiver
// Assumes: baud chosen by parameter, sync byte sent by user first
// Notes: paces on ready, waits after select change
`timescale 1ns/1ps
module srx_host #(
  parameter int BIT_CYC = 868, // cycles per bit
  parameter int STOP_BITS = 1, // one or two
  parameter int SEL_WAIT = srx_pkg::SEL_WAIT_CYC // select settle
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset, active high
  srx_if.host link, // serial link
  input wire logic [7:0] txData, // byte to send
  input wire logic txValid, // byte offered
  output logic txReady, // byte taken
  input wire logic selectIn, // high selects the display
  output logic sendBusy // character in flight
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [2:0] {
    SHI_IDLE = 3'b001, SHI_SEND = 3'b010, SHI_WAIT = 3'b100
  } srx_hst_e;
  srx_hst_e state_reg, state_next;
  logic [9:0] shift_reg, shift_next; // start, data, stop
  logic [3:0] bitCnt_reg, bitCnt_next; // bits left
  logic [15:0] tick_reg, tick_next; // bit timer
  logic [15:0] selCnt_reg, selCnt_next; // settle timer
  logic sel_reg, sel_next; // select level out
  logic rx_reg, rx_next; // line level out
  logic take_reg, take_next; // accept strobe
  logic busy_reg, busy_next; // character in flight
  logic readyLow; // device ready seen
  localparam int DATA_BITS_P = srx_pkg::DATA_BITS; // data bits per char
  // treat released ready as low (not paced)
  assign readyLow = link.hostReadyNOe | ~link.hostReadyNOut;
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    bitCnt_next = bitCnt_reg;
    tick_next = tick_reg;
    selCnt_next = selCnt_reg;
    sel_next = selectIn;
    rx_next = rx_reg;
    take_next = 1'b0;
    if (selectIn != sel_reg) begin
      selCnt_next = 16'(SEL_WAIT);
    end else if (selCnt_reg != 16'h0000) begin
      selCnt_next = selCnt_reg - 16'h0001;
    end
    case (state_reg)
      SHI_IDLE: begin
        rx_next = 1'b1;
        // start only while ready low and settled; a deselected display
        // shares the line, so sending to the others goes on meanwhile
        if (txValid && readyLow && selCnt_reg == 16'h0000) begin
          shift_next = {1'b1, txData, 1'b0};
          bitCnt_next = 4'(DATA_BITS_P + 1);
          tick_next = 16'(BIT_CYC - 1);
          rx_next = 1'b0;
          take_next = 1'b1;
          state_next = SHI_SEND;
        end
      end
      SHI_SEND: begin
        if (tick_reg == 16'h0000) begin
          shift_next = {1'b1, shift_reg[9:1]};
          rx_next = shift_reg[1];
          tick_next = 16'(BIT_CYC - 1);
          if (bitCnt_reg == 4'h0) begin
            // extra stop time doubles as inter-character pause
            tick_next = 16'(BIT_CYC * STOP_BITS - 1);
            rx_next = 1'b1;
            state_next = SHI_WAIT;
          end else begin
            bitCnt_next = bitCnt_reg - 4'h1;
          end
        end else begin
          tick_next = tick_reg - 16'h0001;
        end
      end
      SHI_WAIT: begin
        if (tick_reg == 16'h0000) begin
          state_next = SHI_IDLE;
        end else begin
          tick_next = tick_reg - 16'h0001;
        end
      end
      default: state_next = SHI_IDLE;
    endcase
    // busy flag registered so the output comes from a flip-flop
    busy_next = (state_next != SHI_IDLE);
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= SHI_IDLE;
      shift_reg <= 10'h3ff;
      bitCnt_reg <= 4'h0;
      tick_reg <= 16'h0000;
      selCnt_reg <= 16'h0000;
      sel_reg <= 1'b1;
      rx_reg <= 1'b1;
      take_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      bitCnt_reg <= bitCnt_next;
      tick_reg <= tick_next;
      selCnt_reg <= selCnt_next;
      sel_reg <= sel_next;
      rx_reg <= rx_next;
      take_reg <= take_next;
      busy_reg <= busy_next;
    end
  end
  assign link.rxLine = rx_reg;
  assign link.displayDisableN = sel_reg;
  assign txReady = take_reg;
  assign sendBusy = busy_reg;
endmodule : srx_host

// [hw/srx_device.sv]
// Purpose: display-side serial receiver with autobaud and pacing
// Assumes: receiver synchronous inputs, interpreter drains buffer
// Notes: two-entry buffer sits before the interpreter
`timescale 1ns/1ps
module srx_device #(
  parameter int BUF_W = 8, // buffer word width
  parameter int SEL_WAIT = srx_pkg::SEL_WAIT_CYC // select settle
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset, active high
  srx_if.dev link, // serial link
  output logic [BUF_W-1:0] rxData, // byte to interpreter
  output logic rxValid, // one-cycle strobe per byte
  input wire logic rxReady, // interpreter can take byte
  output logic baudLocked, // rate detected
  output logic [2:0] rateSel, // chosen candidate index
  output logic restoreDefaults // pulse: restore factory settings
);
  // ----------------------------------------
  // types and state
  // ----------------------------------------
  typedef enum logic [4:0] {
    SDV_SYNC = 5'b00001, SDV_START = 5'b00010, SDV_DATA = 5'b00100,
    SDV_STOP = 5'b01000, SDV_IDLE = 5'b10000
  } srx_dev_e;
  srx_dev_e state_reg, state_next;
  logic rxPrev_reg, rxPrev_next; // last line level
  logic [15:0] tick_reg, tick_next; // bit timer
  logic [15:0] meas_reg, meas_next; // start-bit length
  logic [15:0] bitCyc_reg, bitCyc_next; // locked bit period
  logic [2:0] rate_reg, rate_next; // chosen rate
  logic locked_reg, locked_next; // rate found
  logic [3:0] bitCnt_reg, bitCnt_next; // data bits taken
  logic [7:0] sh_reg, sh_next; // data shifter
  logic [15:0] selCnt_reg, selCnt_next; // settle after select
  logic en_reg, en_next; // receiver attached
  logic boot_reg, boot_next; // power-up sampling done
  logic rst_reg, rst_next; // restore pulse
  logic push; // byte into buffer
  logic [7:0] pushData; // that byte
  // two-entry buffer
  logic [BUF_W-1:0] mem_reg [2], mem_next [2];
  logic [1:0] cnt_reg, cnt_next; // words held
  logic rdPtr_reg, rdPtr_next, wrPtr_reg, wrPtr_next;
  logic vld_reg, vld_next; // output strobe
  logic [BUF_W-1:0] out_reg, out_next; // output byte
  logic rdyN_reg, rdyN_next; // ready level
  logic rdyOe_reg, rdyOe_next; // ready enable
  logic nearest; // line level seen
  assign nearest = link.rxLine;
  // ----------------------------------------
  // closest candidate rate to a bit period
  // ----------------------------------------
  function automatic logic [2:0] srx_pick(input logic [15:0] cyc);
    logic [2:0] best;
    logic [15:0] bd, d, c;
    best = 3'h0;
    bd = 16'hffff;
    for (int i = 0; i < srx_pkg::NUM_RATES; i++) begin
      c = srx_pkg::srx_rate_cyc(i);
      d = (cyc > c) ? cyc - c : c - cyc;
      if (d < bd) begin
        bd = d;
        best = 3'(i);
      end
    end
    return best;
  endfunction : srx_pick
  // ----------------------------------------
  // receiver next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    rxPrev_next = en_reg ? nearest : 1'b1;
    tick_next = tick_reg;
    meas_next = meas_reg;
    bitCyc_next = bitCyc_reg;
    rate_next = rate_reg;
    locked_next = locked_reg;
    bitCnt_next = bitCnt_reg;
    sh_next = sh_reg;
    push = 1'b0;
    pushData = sh_reg;
    en_next = link.displayDisableN;
    selCnt_next = (selCnt_reg != 16'h0000) ? selCnt_reg - 16'h0001 : 16'h0000;
    if (link.displayDisableN != en_reg) selCnt_next = 16'(SEL_WAIT);
    boot_next = 1'b1;
    rst_next = ~boot_reg & ~link.displayDisableN;
    if (!en_reg) begin
      // detached: drop any frame in progress
      state_next = locked_reg ? SDV_IDLE : SDV_SYNC;
    end else begin
      case (state_reg)
        SDV_SYNC: begin
          // measure low run of start bit of carriage return
          if (rxPrev_reg && !nearest) begin
            meas_next = 16'h0001;
          end else if (!nearest && meas_reg != 16'hffff) begin
            meas_next = meas_reg + 16'h0001;
          end else if (nearest && !rxPrev_reg && meas_reg != 16'h0000) begin
            // cr has one low start bit then a high bit
            rate_next = srx_pick(meas_reg);
            bitCyc_next = srx_pkg::srx_rate_cyc(int'(srx_pick(meas_reg)));
            meas_next = 16'h0000;
            // rest of sync char runs through the data path; the stop
            // stage drops it since the rate is not locked yet
            state_next = SDV_DATA;
            bitCnt_next = 4'h0;
            tick_next = srx_pkg::srx_rate_cyc(int'(srx_pick(meas_reg)));
          end
        end
        SDV_IDLE: begin
          if (rxPrev_reg && !nearest) begin
            tick_next = {1'b0, bitCyc_reg[15:1]};
            state_next = SDV_START;
          end
        end
        SDV_START: begin
          if (tick_reg == 16'h0000) begin
            // false start if line back high mid-bit
            state_next = nearest ? SDV_IDLE : SDV_DATA;
            tick_next = bitCyc_reg;
            bitCnt_next = 4'h0;
          end else tick_next = tick_reg - 16'h0001;
        end
        SDV_DATA: begin
          if (tick_reg == 16'h0000) begin
            sh_next = {nearest, sh_reg[7:1]};
            tick_next = bitCyc_reg;
            bitCnt_next = bitCnt_reg + 4'h1;
            if (bitCnt_reg == 4'(srx_pkg::DATA_BITS - 1)) state_next = SDV_STOP;
          end else tick_next = tick_reg - 16'h0001;
        end
        SDV_STOP: begin
          // one stop bit checked; a second just reads as idle
          if (tick_reg == 16'h0000) begin
            if (locked_reg && nearest) begin
              push = 1'b1;
              pushData = sh_reg;
            end
            locked_next = 1'b1;
            state_next = SDV_IDLE;
          end else tick_next = tick_reg - 16'h0001;
        end
        default: state_next = SDV_SYNC;
      endcase
    end
  end
  // ----------------------------------------
  // buffer and pacing next state
  // ----------------------------------------
  always_comb begin
    logic pop;
    pop = 1'b0;
    mem_next = mem_reg;
    cnt_next = cnt_reg;
    rdPtr_next = rdPtr_reg;
    wrPtr_next = wrPtr_reg;
    out_next = out_reg;
    vld_next = 1'b0;
    if (cnt_reg != 2'h0 && rxReady) begin
      pop = 1'b1;
      out_next = mem_reg[rdPtr_reg];
      vld_next = 1'b1;
      rdPtr_next = ~rdPtr_reg;
    end
    if (push && cnt_reg != 2'h2) begin
      mem_next[wrPtr_reg] = BUF_W'(pushData);
      wrPtr_next = ~wrPtr_reg;
    end
    cnt_next = cnt_reg + ((push && cnt_reg != 2'h2) ? 2'h1 : 2'h0)
             - (pop ? 2'h1 : 2'h0);
    // free while awaiting the sync char; busy once it starts until
    // locked, while a word waits, the interpreter stalls, or just
    // after reattach while the receiver settles
    rdyN_next = (~locked_reg & ~((state_reg == SDV_SYNC)
                 & (meas_reg == 16'h0000)))
              | (cnt_next != 2'h0) | ~rxReady
              | (selCnt_reg != 16'h0000);
    rdyOe_next = ~en_reg;
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= SDV_SYNC;
      rxPrev_reg <= 1'b1;
      tick_reg <= 16'h0000;
      meas_reg <= 16'h0000;
      bitCyc_reg <= 16'h0000;
      rate_reg <= 3'h0;
      locked_reg <= 1'b0;
      bitCnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      selCnt_reg <= 16'h0000;
      en_reg <= 1'b1;
      boot_reg <= 1'b0;
      rst_reg <= 1'b0;
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      cnt_reg <= 2'h0;
      rdPtr_reg <= 1'b0;
      wrPtr_reg <= 1'b0;
      vld_reg <= 1'b0;
      out_reg <= '0;
      rdyN_reg <= 1'b1;
      rdyOe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      rxPrev_reg <= rxPrev_next;
      tick_reg <= tick_next;
      meas_reg <= meas_next;
      bitCyc_reg <= bitCyc_next;
      rate_reg <= rate_next;
      locked_reg <= locked_next;
      bitCnt_reg <= bitCnt_next;
      sh_reg <= sh_next;
      selCnt_reg <= selCnt_next;
      en_reg <= en_next;
      boot_reg <= boot_next;
      rst_reg <= rst_next;
      mem_reg <= mem_next;
      cnt_reg <= cnt_next;
      rdPtr_reg <= rdPtr_next;
      wrPtr_reg <= wrPtr_next;
      vld_reg <= vld_next;
      out_reg <= out_next;
      rdyN_reg <= rdyN_next;
      rdyOe_reg <= rdyOe_next;
    end
  end
  assign link.hostReadyNOut = rdyN_reg;
  assign link.hostReadyNOe = rdyOe_reg;
  assign link.txLineOe = 1'b1;
  assign rxData = out_reg;
  assign rxValid = vld_reg;
  assign baudLocked = locked_reg;
  assign rateSel = rate_reg;
  assign restoreDefaults = rst_reg;
endmodule : srx_device

// [tb/srx_chk.sv]
// Purpose: interface checks on the link between host and display
// Assumes: host frames of one start, 8 data, one stop bit
// Notes: a frame counter follows each host character sent while the display is selected
`timescale 1ns/1ps
module srx_chk #(
  parameter int BIT_CYC = 868, // cycles per bit
  parameter int SELW = 10 // select settle cycles
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic rxLine, // serial data
  input wire logic hostReadyNOut, // ready level, low means ready
  input wire logic hostReadyNOe, // low while device drives ready
  input wire logic displayDisableN, // low detaches device
  input wire logic txLineOe // transmit enable, must stay high
);
  // --------------------------------------
  // frame tracking
  // --------------------------------------
  localparam int HALF = BIT_CYC / 2; // middle of start bit
  localparam int STOPM = 9 * BIT_CYC + HALF; // middle of stop bit
  localparam int FRAME = 10 * BIT_CYC; // one whole character
  localparam int RELW = SELW + 8; // bound on select response
  logic lineReg; // line level one cycle back
  logic seenReg; // first character already passed
  logic seenNext; // next value of seenReg
  logic [15:0] frameReg; // cycles since start edge
  logic [15:0] frameNext; // next value of frameReg
  logic startSeen; // fall from idle outside a frame
  logic readyOk; // host allowed to start
  assign startSeen = lineReg && !rxLine && (frameReg == 16'h0000)
    && displayDisableN;
  assign readyOk = !hostReadyNOut || hostReadyNOe;
  // next frame count and first-character flag
  always_comb begin
    frameNext = frameReg;
    seenNext = seenReg || startSeen;
    if (startSeen) begin
      frameNext = 16'h0001;
    end else if (frameReg == 16'(FRAME - 1)) begin
      frameNext = 16'h0000; // frame over
    end else if (frameReg != 16'h0000) begin
      frameNext = frameReg + 16'h0001;
    end
  end
  // register the helper state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lineReg <= 1'b1;
      seenReg <= 1'b0;
      frameReg <= 16'h0000;
    end else begin
      lineReg <= rxLine;
      seenReg <= seenNext;
      frameReg <= frameNext;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // --------------------------------------
  // assertions
  // --------------------------------------
  AST_TX_NEVER: assert property (txLineOe)
    else $error("transmit line enabled");
  AST_RST_BUSY: assert property (
    $fell(sys_rst) |-> hostReadyNOut && !hostReadyNOe)
    else $error("ready not busy after reset");
  AST_START_LEN: assert property (
    frameReg == 16'(HALF) |-> !rxLine)
    else $error("start bit not low at middle");
  AST_STOP_HIGH: assert property (
    frameReg == 16'(STOPM) |-> rxLine)
    else $error("stop bit not high at middle");
  AST_START_READY: assert property (
    startSeen && seenReg |-> $past(readyOk))
    else $error("character started while busy");
  AST_DIS_RELEASE: assert property (
    $fell(displayDisableN) |-> ##[0:RELW] hostReadyNOe)
    else $error("ready not released when disabled");
  AST_DIS_STAY: assert property (
    hostReadyNOe && !displayDisableN |=> hostReadyNOe)
    else $error("disabled device drove ready");
  AST_SEL_WAIT: assert property (
    $rose(displayDisableN) |-> rxLine [*8])
    else $error("data sent right after select");
  AST_SEL_DRIVE: assert property (
    $rose(displayDisableN) |-> ##[0:RELW] !hostReadyNOe)
    else $error("ready not driven after select");
  // main scenarios reached
  CV_START: cover property (startSeen && seenReg);
  CV_DESEL: cover property ($fell(displayDisableN));
  CV_STOP: cover property (frameReg == 16'(STOPM) && rxLine);
endmodule : srx_chk

// [tb/tb_serial_rx_handshake_select.sv]
// Purpose: host and display ends joined, random and corner bytes
// Assumes: 115200 baud host, select settle shortened to 10 cycles
// Notes: a second display held disabled from power-up
`timescale 1ns/1ps
module tb_serial_rx_handshake_select;
  logic clk; // system clock
  logic sysRst; // reset, active high
  logic [7:0] txData; // byte to host
  logic txValid, txReady, selectIn, sendBusy; // host user side
  logic [7:0] rxData; // byte from display
  logic rxValid, rxReady, baudLocked; // display user side
  logic [2:0] rateSel; // chosen rate index
  logic rxValid2, restore2; // disabled display outputs
  int error_cnt = 0, num_checks = 0, seed = 34;
  int restoreCnt = 0, valid2Cnt = 0, cyc = 0, n, i;
  logic [7:0] gotQ[$]; // bytes handed on
  logic [7:0] b; // current byte
  logic lowSeen; // line left idle
  logic [7:0] corner[3] = '{8'h00, 8'hff, 8'h55}; // edge patterns
  srx_if lnk();
  srx_if lnk2();
  srx_host #(.SEL_WAIT(10)) u_srx_host (
    .clk(clk), .sys_rst(sysRst), .link(lnk.host), .txData(txData),
    .txValid(txValid), .txReady(txReady), .selectIn(selectIn),
    .sendBusy(sendBusy));
  srx_device #(.SEL_WAIT(10)) u_srx_device (
    .clk(clk), .sys_rst(sysRst), .link(lnk.dev), .rxData(rxData),
    .rxValid(rxValid), .rxReady(rxReady), .baudLocked(baudLocked),
    .rateSel(rateSel), .restoreDefaults());
  srx_device #(.SEL_WAIT(10)) u_srx_device_2 (
    .clk(clk), .sys_rst(sysRst), .link(lnk2.dev), .rxData(),
    .rxValid(rxValid2), .rxReady(rxReady), .baudLocked(), .rateSel(),
    .restoreDefaults(restore2));
  srx_chk #(.SELW(10)) u_srx_chk (
    .clk(clk), .sys_rst(sysRst), .rxLine(lnk.rxLine),
    .hostReadyNOut(lnk.hostReadyNOut), .hostReadyNOe(lnk.hostReadyNOe),
    .displayDisableN(lnk.displayDisableN), .txLineOe(lnk.txLineOe));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // collect handed-on bytes; toggle the disabled display's line
  always @(posedge clk) begin
    if (rxValid === 1'b1) gotQ.push_back(rxData);
    if (restore2 === 1'b1) restoreCnt++;
    if (rxValid2 === 1'b1) valid2Cnt++;
    cyc++;
    lnk2.rxLine <= 1'(cyc >> 9);
  end
  task automatic chk8(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk8
  task automatic chkBit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %b got %b", nm, e, g);
    end
  endtask : chkBit
  // highest candidate rate whose bit period fits the host's period
  function automatic logic [7:0] expRate(input int cyc);
    int r[6] = '{9600, 14400, 19200, 38400, 57600, 115200};
    expRate = 8'h00;
    for (int k = 0; k < 6; k++) begin
      if (cyc >= 100_000_000 / r[k]) expRate = 8'(k);
    end
  endfunction : expRate
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  // offer a byte, hold it until the host takes it
  task automatic sendByte(input logic [7:0] v);
    int k;
    txData <= v;
    txValid <= 1'b1;
    for (k = 0; k < 30000; k++) begin
      @(posedge clk);
      if (txReady === 1'b1) break;
    end
    txValid <= 1'b0;
    if (k == 30000) begin
      chkBit("host take", 1'b1, 1'b0);
      stop_test();
    end
  endtask : sendByte
  // bounded wait for one handed-on byte
  task automatic waitByte(input logic [7:0] e);
    int k;
    for (k = 0; k < 30000 && gotQ.size() == 0; k++) @(posedge clk);
    if (gotQ.size() == 0) begin
      chkBit("byte out", 1'b1, 1'b0);
      stop_test();
    end
    chk8("rx byte", e, gotQ.pop_front());
  endtask : waitByte
  initial begin
    sysRst = 1'b1;
    txData = 8'h00;
    txValid = 1'b0;
    selectIn = 1'b1;
    rxReady = 1'b1;
    lnk2.displayDisableN = 1'b0;
    repeat (10) @(posedge clk);
    chkBit("busy at reset", 1'b1, lnk.hostReadyNOut);
    sysRst <= 1'b0;
    repeat (3) @(posedge clk);
    chkBit("ready for sync", 1'b0, lnk.hostReadyNOut);
    chkBit("tx unused", 1'b1, lnk.txLineOe);
    chkBit("restore once", 1'b1, restoreCnt == 1);
    chkBit("dis released", 1'b1, lnk2.hostReadyNOe);
    sendByte(8'h0d);
    for (n = 0; n < 20000 && baudLocked !== 1'b1; n++) @(posedge clk);
    repeat (20) @(posedge clk);
    chkBit("locked", 1'b1, baudLocked);
    chk8("rate", expRate(868), {5'h00, rateSel});
    chkBit("sync kept", 1'b0, gotQ.size() != 0);
    chkBit("ready free", 1'b0, lnk.hostReadyNOut);
    for (i = 0; i < 5; i++) begin
      b = (i < 3) ? corner[i] : 8'($random(seed));
      sendByte(b);
      waitByte(b);
    end
    // interpreter stall: ready goes busy and host holds off
    rxReady <= 1'b0;
    repeat (5) @(posedge clk);
    chkBit("ready busy", 1'b1, lnk.hostReadyNOut);
    lowSeen = 1'b0;
    txData <= 8'ha5;
    txValid <= 1'b1;
    repeat (2000) begin
      @(posedge clk);
      if (lnk.rxLine !== 1'b1) lowSeen = 1'b1;
    end
    chkBit("held off", 1'b0, lowSeen);
    rxReady <= 1'b1;
    sendByte(8'ha5);
    waitByte(8'ha5);
    // deselect: ready released, line ignored
    selectIn <= 1'b0;
    repeat (40) @(posedge clk);
    chkBit("released", 1'b1, lnk.hostReadyNOe);
    sendByte(8'h3c);
    for (n = 0; n < 12000 && sendBusy !== 1'b0; n++) @(posedge clk);
    chkBit("host idle", 1'b0, sendBusy);
    repeat (200) @(posedge clk);
    chkBit("ignored", 1'b0, gotQ.size() != 0);
    selectIn <= 1'b1;
    repeat (40) @(posedge clk);
    chkBit("driven", 1'b0, lnk.hostReadyNOe);
    sendByte(8'hc3);
    waitByte(8'hc3);
    chkBit("dis ignored", 1'b0, valid2Cnt != 0);
    stop_test();
  end
endmodule : tb_serial_rx_handshake_select
